// ===== rtl/sbo_regs.svh
// Offsets, field positions, reset values and timing counts of the
// subcarrier, burst and composite output register group.
// Assumes byte-wide registers on the parallel host port.
`ifndef SBO_REGS_SVH
`define SBO_REGS_SVH

// Register offsets on the host port
`define SBO_OFS_OUT_CFG 8'h3f
`define SBO_OFS_INC_B0 8'h40
`define SBO_OFS_INC_B1 8'h41
`define SBO_OFS_INC_B2 8'h42
`define SBO_OFS_INC_B3 8'h43
`define SBO_OFS_VPH_LO 8'h44
`define SBO_OFS_VPH_HI 8'h45
`define SBO_OFS_BPH_LO 8'h46
`define SBO_OFS_BPH_HI 8'h47
`define SBO_OFS_PEAK 8'h48
`define SBO_OFS_STEP1 8'h49
`define SBO_OFS_STEP2 8'h4a
`define SBO_OFS_FIRST 8'h3f
`define SBO_OFS_LAST 8'h4a
`define SBO_REG_COUNT 12

// Field positions of the output configuration register
`define SBO_BIT_SOURCE_SEL 7
`define SBO_BIT_FILTER_BYP 5
`define SBO_BIT_CLOCK_SEL 4
`define SBO_BIT_OFFSET_EN 3
`define SBO_OUT_CFG_MASK 8'hb8

// Reset values
`define SBO_RESET_BYTE 8'h00
`define SBO_CHROMA_OFFSET 11'h100

// Master clock cycles per pixel clock period
`define SBO_PIX_DIVIDE 2

`endif

// ===== rtl/sbo_pkg.sv
// Types used by the register group; its output stage does not use them.
// Assumes the constants header is included by the files that need it.
package sbo_pkg;

   // Host port access state
   typedef enum logic [0:0] {
      SBO_IDLE = 1'b0,
      SBO_ACCESS = 1'b1
   } sbo_bus_state_t;

   typedef logic [7:0] sbo_byte_t;

endpackage

// ===== rtl/sbo_out_if.sv
// Signals between the register group and the composite output stage.
// Assumes both ends run on the master clock.
`timescale 1ns/10ps
`default_nettype none

interface sbo_out_if #(
   parameter int PIX_W = 10
);
   logic source_select;
   logic clock_select;
   logic offset_enable;
   logic [PIX_W-1:0] pix_interp;
   logic [PIX_W-1:0] pix_plain;
   logic [PIX_W-1:0] second_in;
   logic [PIX_W-1:0] digital_out;
   logic [PIX_W:0] second_out;
   logic pix_phase;

   modport ctrl (
      output source_select,
      output clock_select,
      output offset_enable,
      output pix_interp,
      output pix_plain,
      output second_in,
      input digital_out,
      input second_out,
      input pix_phase
   );

   modport stage (
      input source_select,
      input clock_select,
      input offset_enable,
      input pix_interp,
      input pix_plain,
      input second_in,
      output digital_out,
      output second_out,
      output pix_phase
   );
endinterface

`default_nettype wire

// ===== rtl/sbo_out_stage.sv
// Digital composite output stage: pixel clock divider, output source
// and clock choice, and the chroma offset on the second composite output.
// Assumes pixel data arrives on the master clock.
`timescale 1ns/10ps
`default_nettype none
`include "sbo_regs.svh"

module sbo_out_stage #(
   parameter int PIX_W = 10
) (
   input wire logic clk,
   input wire logic rst,
   sbo_out_if.stage io
);

   logic pix_phase;
   logic next_pix_phase;
   logic [PIX_W-1:0] digital_out;
   logic [PIX_W-1:0] next_digital_out;
   logic [PIX_W:0] second_out;
   logic [PIX_W:0] next_second_out;
   logic [PIX_W:0] offset;

   // Refuse settings the divider and the offset cannot serve
   if (`SBO_PIX_DIVIDE != 2) begin : g_bad_divide
      $error("sbo_out_stage: pixel divider must be two");
   end
   if (PIX_W < 9) begin : g_bad_width
      $error("sbo_out_stage: PIX_W too narrow for the offset");
   end

   // Next values of the divider and both outputs
   always_comb begin
      next_pix_phase = ~pix_phase;
      next_digital_out = digital_out;
      // Master clock updates every edge, pixel clock on its rising phase
      if (!io.clock_select || !pix_phase) begin
         next_digital_out = io.source_select ? io.pix_interp
                                             : io.pix_plain;
      end
      offset = io.offset_enable ? (PIX_W+1)'(`SBO_CHROMA_OFFSET)
                                : '0;
      next_second_out = {1'b0, io.second_in} + offset;
   end

   // Output registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pix_phase <= 1'b0;
         digital_out <= '0;
         second_out <= '0;
      end else begin
         pix_phase <= next_pix_phase;
         digital_out <= next_digital_out;
         second_out <= next_second_out;
      end
   end

   assign io.digital_out = digital_out;
   assign io.second_out = second_out;
   assign io.pix_phase = pix_phase;

endmodule

`default_nettype wire

// ===== rtl/sbo_top.sv
// Subcarrier, burst and composite output register group behind the
// parallel host port, with the digital composite output stage.
// Assumes host pins are asynchronous to clk, chip select low for at
// least four master clocks, and pixel data arriving on clk.
//
// What this block does
// - Output bit 7 picks interpolated or plain pixels for composite out.
// - Output bit 5 set bypasses the Gaussian filter, clear enables it.
// - Output bit 4 picks master or pixel clock for composite out.
// - Output bit 3 set adds 256 to the second composite output.
// - Subcarrier word is bytes 0x40 to 0x43, least significant first.
// - Video phase offset is 0x44 low byte and 0x45 high byte.
// - Burst phase offset is 0x46 low byte and 0x47 high byte.
// - Register 0x48 holds the peak burst amplitude for U, or U and V.
// - Burst envelope midpoint is derived from the peak amplitude.
// - Register 0x49 holds the first intermediate burst envelope step.
// - Register 0x4A holds the second intermediate burst envelope step.
// - Pixel clock is half the master clock.
`timescale 1ns/10ps
`default_nettype none
`include "sbo_regs.svh"

module sbo_top #(
   parameter int PIX_W = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic host_cs_n,
   input wire logic host_read,
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_drive_n,
   input wire logic [PIX_W-1:0] pix_interp,
   input wire logic [PIX_W-1:0] pix_plain,
   input wire logic [PIX_W-1:0] second_composite_in,
   output logic [PIX_W-1:0] digital_composite_out,
   output logic [PIX_W:0] second_composite_out,
   output logic pixel_clock,
   output logic output_source_select,
   output logic shaping_filter_bypass,
   output logic composite_clock_select,
   output logic chroma_output_offset_enable,
   output logic [31:0] subcarrier_increment_word,
   output logic [15:0] video_phase_offset,
   output logic [15:0] burst_phase_offset,
   output logic [7:0] burst_peak_amplitude,
   output logic [7:0] burst_mid_amplitude,
   output logic [7:0] burst_step_one,
   output logic [7:0] burst_step_two
);

   localparam int NREG = `SBO_REG_COUNT;

   // Pin synchronisers, first and second stages
   logic cs_n_m;
   logic cs_n_s;
   logic read_m;
   logic read_s;
   logic [7:0] addr_m;
   logic [7:0] addr_s;
   logic [7:0] din_m;
   logic [7:0] din_s;

   // Access tracking
   sbo_pkg::sbo_bus_state_t state;
   sbo_pkg::sbo_bus_state_t next_state;
   logic acc_read;
   logic next_acc_read;
   logic [7:0] acc_addr;
   logic [7:0] next_acc_addr;
   logic [7:0] acc_data;
   logic [7:0] next_acc_data;
   logic commit;

   // Register storage and read path
   sbo_pkg::sbo_byte_t regs [NREG];
   sbo_pkg::sbo_byte_t next_regs [NREG];
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic drive_n;
   logic next_drive_n;

   sbo_out_if #(.PIX_W(PIX_W)) out_bus ();

   // Refuse widths that cannot carry the chroma offset
   if (PIX_W < 9 || PIX_W > 16) begin : g_bad_width
      $error("sbo_top: PIX_W must be 9 to 16 to hold the offset");
   end

   // The storage must cover every offset of the group
   if (`SBO_OFS_LAST - `SBO_OFS_FIRST + 1 != NREG) begin : g_bad_count
      $error("sbo_top: register count does not match the offsets");
   end

   // True when the offset falls inside this register group
   function automatic logic in_group(input logic [7:0] a);
      in_group = (a >= `SBO_OFS_FIRST) && (a <= `SBO_OFS_LAST);
   endfunction

   // Storage index of an offset inside the group
   function automatic logic [3:0] reg_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - `SBO_OFS_FIRST;
      reg_index = d[3:0];
   endfunction

   // Reserved output configuration bits are kept at zero
   function automatic logic [7:0] write_mask(input logic [7:0] a);
      write_mask = (a == `SBO_OFS_OUT_CFG) ? `SBO_OUT_CFG_MASK
                                           : 8'hff;
   endfunction

   // Two flip-flop synchronisers on every host pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_n_m <= 1'b1;
         cs_n_s <= 1'b1;
         read_m <= 1'b0;
         read_s <= 1'b0;
         addr_m <= 8'h00;
         addr_s <= 8'h00;
         din_m <= 8'h00;
         din_s <= 8'h00;
      end else begin
         cs_n_m <= host_cs_n;
         cs_n_s <= cs_n_m;
         read_m <= host_read;
         read_s <= read_m;
         addr_m <= host_addr;
         addr_s <= addr_m;
         din_m <= host_data_in;
         din_s <= din_m;
      end
   end

   // Access state: capture while selected, commit a write on release
   always_comb begin
      next_state = state;
      next_acc_read = acc_read;
      next_acc_addr = acc_addr;
      next_acc_data = acc_data;
      commit = 1'b0;
      case (state)
         sbo_pkg::SBO_IDLE: begin
            if (!cs_n_s) begin
               next_state = sbo_pkg::SBO_ACCESS;
               next_acc_read = read_s;
               next_acc_addr = addr_s;
               next_acc_data = din_s;
            end
         end
         sbo_pkg::SBO_ACCESS: begin
            if (!cs_n_s) begin
               next_acc_read = read_s;
               next_acc_addr = addr_s;
               next_acc_data = din_s;
            end else begin
               next_state = sbo_pkg::SBO_IDLE;
               commit = !acc_read;
            end
         end
         default: begin
            next_state = sbo_pkg::SBO_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= sbo_pkg::SBO_IDLE;
         acc_read <= 1'b0;
         acc_addr <= 8'h00;
         acc_data <= 8'h00;
      end else begin
         state <= next_state;
         acc_read <= next_acc_read;
         acc_addr <= next_acc_addr;
         acc_data <= next_acc_data;
      end
   end

   // Register file: each byte holds until a write to its own offset
   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         next_regs[i] = regs[i];
      end
      if (commit && in_group(acc_addr)) begin
         next_regs[reg_index(acc_addr)] =
            acc_data & write_mask(acc_addr);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NREG; i++) begin
            regs[i] <= `SBO_RESET_BYTE;
         end
      end else begin
         for (int i = 0; i < NREG; i++) begin
            regs[i] <= next_regs[i];
         end
      end
   end

   // Read path: addressed byte, zero outside the group
   always_comb begin
      next_rdata = 8'h00;
      if (in_group(addr_s)) begin
         next_rdata = regs[reg_index(addr_s)];
      end
      next_drive_n = !((state == sbo_pkg::SBO_ACCESS) && !cs_n_s
                       && read_s);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
         drive_n <= 1'b1;
      end else begin
         rdata <= next_rdata;
         drive_n <= next_drive_n;
      end
   end

   assign host_data_out = rdata;
   assign host_data_drive_n = drive_n;

   // Output configuration fields
   localparam int CFG = 0;
   assign output_source_select = regs[CFG][`SBO_BIT_SOURCE_SEL];
   assign shaping_filter_bypass = regs[CFG][`SBO_BIT_FILTER_BYP];
   assign composite_clock_select = regs[CFG][`SBO_BIT_CLOCK_SEL];
   assign chroma_output_offset_enable =
      regs[CFG][`SBO_BIT_OFFSET_EN];

   // Multi-byte words joined from their held bytes
   assign subcarrier_increment_word = {regs[4], regs[3],
                                       regs[2], regs[1]};
   assign video_phase_offset = {regs[6], regs[5]};
   assign burst_phase_offset = {regs[8], regs[7]};

   // Burst envelope heights
   assign burst_peak_amplitude = regs[9];
   assign burst_mid_amplitude = {1'b0, regs[9][7:1]};
   assign burst_step_one = regs[10];
   assign burst_step_two = regs[11];

   // Feed the output stage
   assign out_bus.source_select = output_source_select;
   assign out_bus.clock_select = composite_clock_select;
   assign out_bus.offset_enable = chroma_output_offset_enable;
   assign out_bus.pix_interp = pix_interp;
   assign out_bus.pix_plain = pix_plain;
   assign out_bus.second_in = second_composite_in;

   sbo_out_stage #(.PIX_W(PIX_W)) u_out (
      .clk(clk),
      .rst(rst),
      .io(out_bus.stage)
   );

   assign digital_composite_out = out_bus.digital_out;
   assign second_composite_out = out_bus.second_out;
   assign pixel_clock = out_bus.pix_phase;

endmodule

`default_nettype wire

// ===== tb/sbo_top_properties.sv
// Concurrent checks on the ports of the register group top module.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module sbo_top_props #(
   parameter int PIX_W = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic host_cs_n,
   input wire logic host_read,
   input wire logic [7:0] host_addr,
   input wire logic [7:0] host_data_in,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_drive_n,
   input wire logic [PIX_W-1:0] pix_interp,
   input wire logic [PIX_W-1:0] pix_plain,
   input wire logic [PIX_W-1:0] second_composite_in,
   input wire logic [PIX_W-1:0] digital_composite_out,
   input wire logic [PIX_W:0] second_composite_out,
   input wire logic pixel_clock,
   input wire logic output_source_select,
   input wire logic shaping_filter_bypass,
   input wire logic composite_clock_select,
   input wire logic chroma_output_offset_enable,
   input wire logic [31:0] subcarrier_increment_word,
   input wire logic [15:0] video_phase_offset,
   input wire logic [15:0] burst_phase_offset,
   input wire logic [7:0] burst_peak_amplitude,
   input wire logic [7:0] burst_mid_amplitude,
   input wire logic [7:0] burst_step_one,
   input wire logic [7:0] burst_step_two
);
   // Byte views of the words as the host reads them, 0x4b reads zero
   wire logic [31:0] phases = {burst_phase_offset, video_phase_offset};
   wire logic [31:0] heights = {8'h00, burst_step_two, burst_step_one,
      burst_peak_amplitude};

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_mid_half;
      burst_mid_amplitude == {1'b0, burst_peak_amplitude[7:1]};
   endproperty
   a_mid_half: assert property (p_mid_half)
      else $error("burst midpoint is not half the peak");

   property p_pix_fall;
      pixel_clock |=> !pixel_clock;
   endproperty
   a_pix_fall: assert property (p_pix_fall)
      else $error("pixel clock high for two cycles");

   property p_pix_rise;
      !pixel_clock ##1 !pixel_clock |-> $past(rst, 2);
   endproperty
   a_pix_rise: assert property (p_pix_rise)
      else $error("pixel clock low for two cycles");

   property p_digital_src;
      !composite_clock_select |=> digital_composite_out ==
         ($past(output_source_select) ? $past(pix_interp) : $past(pix_plain));
   endproperty
   a_digital_src: assert property (p_digital_src)
      else $error("composite out does not follow the chosen source");

   property p_digital_hold;
      composite_clock_select && pixel_clock |=>
         $stable(digital_composite_out);
   endproperty
   a_digital_hold: assert property (p_digital_hold)
      else $error("composite out moved off the pixel clock");

   property p_digital_pix;
      composite_clock_select && !pixel_clock |=> digital_composite_out ==
         ($past(output_source_select) ? $past(pix_interp) : $past(pix_plain));
   endproperty
   a_digital_pix: assert property (p_digital_pix)
      else $error("composite out missed a pixel clock update");

   property p_second;
      1'b1 |=> second_composite_out == {1'b0, $past(second_composite_in)} +
         ($past(chroma_output_offset_enable) ? (PIX_W+1)'(256) : '0);
   endproperty
   a_second: assert property (p_second)
      else $error("second composite offset wrong");

   property p_cfg_rd;
      !host_data_drive_n && host_addr == 8'h3f |-> host_data_out ==
         {output_source_select, 1'b0, shaping_filter_bypass,
          composite_clock_select, chroma_output_offset_enable, 3'b000};
   endproperty
   a_cfg_rd: assert property (p_cfg_rd)
      else $error("output config read differs from its fields");

   property p_inc_rd;
      !host_data_drive_n && host_addr[7:2] == 6'h10 |-> host_data_out ==
         subcarrier_increment_word[host_addr[1:0]*8 +: 8];
   endproperty
   a_inc_rd: assert property (p_inc_rd)
      else $error("increment byte read differs from the word");

   property p_phase_rd;
      !host_data_drive_n && host_addr[7:2] == 6'h11 |->
         host_data_out == phases[host_addr[1:0]*8 +: 8];
   endproperty
   a_phase_rd: assert property (p_phase_rd)
      else $error("phase byte read differs from the offset");

   property p_height_rd;
      !host_data_drive_n && host_addr[7:2] == 6'h12 |->
         host_data_out == heights[host_addr[1:0]*8 +: 8];
   endproperty
   a_height_rd: assert property (p_height_rd)
      else $error("burst height read differs from the output");

   property p_hold;
      host_cs_n [*8] |=> $stable(subcarrier_increment_word) &&
         $stable(phases) && $stable(heights);
   endproperty
   a_hold: assert property (p_hold)
      else $error("register changed with no host access");
endmodule
`default_nettype wire

// ===== tb/sbo_host_model.sv
// Host processor model on the parallel register port.
// Assumes select low for 5 and high for 8 master clocks per access.
`timescale 1ns/10ps
`default_nettype none
module sbo_host_model (
   input wire logic clk,
   input wire logic obey_reserved,
   output logic host_cs_n,
   output logic host_read,
   output logic [7:0] host_addr,
   output logic [7:0] host_data_in,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_drive_n
);
   initial begin
      host_cs_n = 1'b1;
      host_read = 1'b1;
      host_addr = 8'h00;
      host_data_in = 8'h5a;
   end

   // Select just after an edge and hold everything for 5 clocks
   task automatic access(input logic rd, input logic [7:0] a,
      input logic [7:0] d);
      @(posedge clk);
      #2;
      host_cs_n = 1'b0;
      host_read = rd;
      host_addr = a;
      host_data_in = d;
      repeat (5) @(posedge clk);
   endtask

   // Deselect; released data bus shows the inverse of the last value
   task automatic release_bus();
      #2;
      host_cs_n = 1'b1;
      host_data_in = ~host_data_in;
      repeat (7) @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (obey_reserved && a == 8'h3f) begin
         v = d & 8'hb8;
      end
      access(1'b0, a, v);
      release_bus();
   endtask

   // Read data and drive state taken while select is still low
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
      output logic dn);
      access(1'b1, a, ~host_data_in);
      d = host_data_out;
      dn = host_data_drive_n;
      release_bus();
   endtask
endmodule
`default_nettype wire

// ===== tb/sbo_top_tb.sv
// Self-checking bench for the subcarrier and burst register group.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module sbo_top_tb;
   localparam int PIX_W = 10;
   logic clk, rst, obey_reserved, host_cs_n, host_read, host_data_drive_n;
   logic [7:0] host_addr, host_data_in, host_data_out;
   logic [PIX_W-1:0] pix_interp, pix_plain, second_composite_in, pix_cnt;
   logic [PIX_W-1:0] digital_composite_out;
   logic [PIX_W:0] second_composite_out;
   logic pixel_clock, output_source_select, shaping_filter_bypass;
   logic composite_clock_select, chroma_output_offset_enable;
   logic [31:0] subcarrier_increment_word;
   logic [15:0] video_phase_offset, burst_phase_offset;
   logic [7:0] burst_peak_amplitude, burst_mid_amplitude;
   logic [7:0] burst_step_one, burst_step_two;
   int num_errors, n_tests;

   sbo_top #(.PIX_W(PIX_W)) i_dut (.*);
   sbo_host_model i_host (.*);

   always #25 clk = ~clk;

   // New pixel values shortly after every edge
   always @(posedge clk) begin
      #2;
      pix_cnt = pix_cnt + 1'b1;
      pix_interp = pix_cnt;
      pix_plain = ~pix_cnt;
      second_composite_in = {pix_cnt[4:0], pix_cnt[9:5]};
   end

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Every register and one unmapped offset read zero after reset
   task automatic t_reset_values();
      logic [7:0] d;
      logic dn;
      chk("drive idle", 1, host_data_drive_n);
      for (int a = 'h3f; a <= 'h4b; a++) begin
         i_host.rd(8'(a), d, dn);
         chk("reset read", 0, d);
         chk("read drive", 0, dn);
      end
   endtask

   // Word assembly, readback, unmapped write and a partial rewrite
   task automatic t_bytes();
      logic [7:0] tv [11] = '{8'h21, 8'h43, 8'h65, 8'h87, 8'ha9, 8'hcb,
         8'hed, 8'h0f, 8'd141, 8'd84, 8'd28};
      logic [7:0] d;
      logic dn;
      for (int i = 0; i < 11; i++) begin
         i_host.wr(8'h40 + 8'(i), tv[i]);
      end
      i_host.wr(8'h4b, 8'hff);
      i_host.rd(8'h4b, d, dn);
      chk("unmapped", 0, d);
      chk("increment", 32'h87654321, subcarrier_increment_word);
      chk("video phase", 32'hcba9, video_phase_offset);
      chk("burst phase", 32'h0fed, burst_phase_offset);
      chk("peak", 141, burst_peak_amplitude);
      chk("mid", 70, burst_mid_amplitude);
      chk("step one", 84, burst_step_one);
      chk("step two", 28, burst_step_two);
      for (int i = 0; i < 11; i++) begin
         i_host.rd(8'h40 + 8'(i), d, dn);
         chk("readback", tv[i], d);
      end
      i_host.wr(8'h42, 8'h00);
      chk("partial", 32'h87004321, subcarrier_increment_word);
   endtask

   // Each output option bit alone, then reserved bits refused
   task automatic t_cfg();
      int bits[4] = '{7, 5, 4, 3};
      logic [7:0] d;
      logic dn;
      for (int k = 0; k < 4; k++) begin
         i_host.wr(8'h3f, 8'(1 << bits[k]));
         chk("cfg flags", {bits[k] == 7, bits[k] == 5,
            bits[k] == 4, bits[k] == 3}, {output_source_select,
            shaping_filter_bypass, composite_clock_select,
            chroma_output_offset_enable});
      end
      obey_reserved = 1'b0;
      i_host.wr(8'h3f, 8'hff);
      i_host.rd(8'h3f, d, dn);
      chk("cfg reserved", 8'hb8, d);
      obey_reserved = 1'b1;
   endtask

   // Source choice, chroma offset, and pixel clock pacing
   task automatic t_outputs();
      logic [9:0] last;
      logic pc;
      int changes;
      for (int m = 0; m < 2; m++) begin
         i_host.wr(8'h3f, m ? 8'h00 : 8'h88);
         repeat (3) begin
            @(posedge clk);
            #1;
            chk("digital out", m ? pix_plain : pix_interp,
               digital_composite_out);
            chk("second out", {1'b0, second_composite_in} +
               (m ? 11'h000 : 11'h100), second_composite_out);
         end
      end
      i_host.wr(8'h3f, 8'h10);
      @(posedge clk);
      #1;
      last = digital_composite_out;
      pc = pixel_clock;
      changes = 0;
      repeat (8) begin
         @(posedge clk);
         #1;
         chk("pixel clock", !pc, pixel_clock);
         chk("digital phase", !pc, digital_composite_out !== last);
         pc = pixel_clock;
         if (digital_composite_out !== last) begin
            changes++;
         end
         last = digital_composite_out;
      end
      chk("digital updates", 4, changes);
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      obey_reserved = 1'b1;
      pix_cnt = '0;
      pix_interp = '0;
      pix_plain = '0;
      second_composite_in = '0;
      num_errors = 0;
      n_tests = 0;
      repeat (4) @(posedge clk);
      #2;
      rst = 1'b0;
      t_reset_values();
      t_bytes();
      t_cfg();
      t_outputs();
      wrap_up();
   end

   // Watchdog well past the expected run of about 630 clocks
   initial begin
      #(50 * 5000);
      num_errors++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule

bind sbo_top sbo_top_props #(.PIX_W(PIX_W)) i_props (.*);
`default_nettype wire
